// ---- core/acs_core.sv ----
// Purpose: Serial link, control register and channel sequencer of a
//          multichannel converter, with an APB status port
// Assumes: Link logic runs on falling sclk; the converter code is valid
//          for the current mux channel by the first falling edge
// Notes:   What this block does is listed below
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module acs_core (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    output logic             dout,
    output logic             dout_oe,
    input  wire logic [11:0] conv_code,
    output logic      [2:0]  mux_chan,
    output logic             range_sel,
    output logic      [1:0]  power_mode
);
    // Searches for the first enabled sequence slot at or after start
    function automatic logic [4:0] find_slot(input logic [15:0] m,
                                             input logic [3:0] start);
        logic [3:0] p;
        logic [4:0] r;
        r = 5'h00;
        for (int k = 15; k >= 0; k--) begin
            p = start + 4'(k);
            if (m[~p]) begin
                r = {1'b1, p};
            end
        end
        return r;
    endfunction

    // Link domain state
    logic              lrst_s1, lrst_s2, lrst_s3, lrst;
    logic              en_s1, en_s2, en_s3, en_link;
    logic              enable;
    logic [4:0]        cnt;
    logic [15:0]       shift;
    logic [11:0]       ctrl;
    logic [15:0]       mask;
    acs_pkg::acs_mode_e mode;
    logic [3:0]        pos;
    logic [15:0]       word;
    logic              wrote;
    acs_pkg::acs_snap_s snap;
    logic              snap_tgl;

    wire logic        frame_on = !cs_n && en_link && cnt != acs_pkg::BIT_DONE;
    wire logic        end_edge = frame_on && cnt == acs_pkg::BIT_LAST;
    wire logic [15:0] next_shift = {shift[14:0], din};
    wire logic [2:0]  addr = ctrl[acs_pkg::CTRL_ADDR_HI:acs_pkg::CTRL_ADDR_LO];
    wire logic [1:0]  pat = {ctrl[acs_pkg::CTRL_SEQ], ctrl[acs_pkg::CTRL_SHADOW]};
    wire logic [11:0] coded = {conv_code[11] ^ ~ctrl[acs_pkg::CTRL_CODING],
                               conv_code[10:0]};
    wire logic [15:0] fresh = {1'b0, mux_chan, coded};
    wire logic [15:0] cur_word = (cnt == 5'h00) ? fresh : word;
    wire logic [3:0]  bit_sel = 4'hE - cnt[3:0];
    wire logic        ctrl_load = frame_on && cnt == acs_pkg::BIT_CTRL_LAST
                                  && mode != acs_pkg::ACS_ARMED
                                  && next_shift[acs_pkg::CTRL_WRITE];
    wire logic [4:0]  first_slot = find_slot(next_shift, 4'h0);
    wire logic [4:0]  step_slot = find_slot(mask, pos + 4'h1);

    acs_pkg::acs_mode_e next_mode;
    logic [2:0]         next_chan;
    logic [3:0]         next_pos;

    // Channel for the following frame, decided at the 16th edge
    always_comb begin
        next_mode = mode;
        next_chan = mux_chan;
        next_pos = pos;
        if (wrote && pat != 2'b10) begin
            next_pos = 4'h0;
            case (pat)
                2'b01: begin
                    next_mode = acs_pkg::ACS_ARMED;
                    next_chan = addr;
                end
                2'b11: begin
                    next_mode = acs_pkg::ACS_CONSEC;
                    next_chan = 3'h0;
                end
                default: begin
                    next_mode = acs_pkg::ACS_SINGLE;
                    next_chan = addr;
                end
            endcase
        end else begin
            case (mode)
                acs_pkg::ACS_ARMED: begin
                    if (first_slot[4]) begin
                        next_mode = acs_pkg::ACS_MASK;
                        next_pos = first_slot[3:0];
                        next_chan = first_slot[2:0];
                    end else begin
                        next_mode = acs_pkg::ACS_SINGLE;
                        next_chan = addr;
                    end
                end
                acs_pkg::ACS_MASK: begin
                    next_pos = step_slot[3:0];
                    next_chan = step_slot[2:0];
                end
                acs_pkg::ACS_CONSEC: begin
                    next_chan = (mux_chan == addr) ? 3'h0 : mux_chan + 3'h1;
                end
                default: begin
                    next_chan = addr;
                end
            endcase
        end
    end

    // Reset and enable enter the link domain through three flops; a change
    // is taken only once the last two agree, so a runt cannot slip through
    always_ff @(negedge sclk) begin
        lrst_s1 <= rst;
        lrst_s2 <= lrst_s1;
        lrst_s3 <= lrst_s2;
        en_s1 <= enable;
        en_s2 <= en_s1;
        en_s3 <= en_s2;
        if (lrst_s2 == lrst_s3) begin
            lrst <= lrst_s3;
        end
        if (en_s2 == en_s3) begin
            en_link <= en_s3;
        end
    end

    always_ff @(negedge sclk) begin
        if (lrst) begin
            cnt <= 5'h00;
            dout <= 1'b0;
            dout_oe <= 1'b0;
        end else if (cs_n || !en_link) begin
            cnt <= 5'h00;
            dout <= 1'b0;
            dout_oe <= 1'b0;
        end else if (frame_on) begin
            cnt <= cnt + 5'h01;
            dout_oe <= 1'b1;
            dout <= (cnt == acs_pkg::BIT_LAST) ? 1'b0 : cur_word[bit_sel];
        end
    end

    always_ff @(negedge sclk) begin
        if (lrst) begin
            shift <= 16'h0000;
            ctrl <= acs_pkg::CTRL_RST;
            mask <= 16'h0000;
            mode <= acs_pkg::ACS_SINGLE;
            pos <= 4'h0;
            word <= 16'h0000;
            wrote <= 1'b0;
            mux_chan <= 3'h0;
            snap <= '0;
            snap_tgl <= 1'b0;
        end else begin
            if (frame_on) begin
                shift <= next_shift;
            end
            if (frame_on && cnt == 5'h00) begin
                word <= fresh;
                wrote <= 1'b0;
            end
            if (ctrl_load) begin
                ctrl <= next_shift[11:0];
                wrote <= 1'b1;
            end
            if (end_edge) begin
                if (mode == acs_pkg::ACS_ARMED && !wrote) begin
                    mask <= next_shift;
                end
                mode <= next_mode;
                pos <= next_pos;
                mux_chan <= next_chan;
                snap <= '{mode: next_mode, ctrl: ctrl, word: word};
                snap_tgl <= ~snap_tgl;
            end
        end
    end

    always_ff @(negedge sclk) begin
        range_sel <= ctrl[acs_pkg::CTRL_RANGE];
        power_mode <= ctrl[acs_pkg::CTRL_PM_HI:acs_pkg::CTRL_PM_LO];
    end

    // Bus domain: snapshot is stable for a whole frame after the toggle
    logic               tg_s1, tg_s2, tg_s3;
    acs_pkg::acs_snap_s status;

    wire logic hit_en = paddr == acs_pkg::OFS_ENABLE;
    wire logic hit_ctl = paddr == acs_pkg::OFS_CONTROL;
    wire logic hit_res = paddr == acs_pkg::OFS_RESULT;
    wire logic setup = psel && !penable;
    wire logic wr_en = psel && penable && pready && pwrite && hit_en;
    wire logic [31:0] rd_val = hit_en ? {31'h0, enable}
                             : hit_ctl ? {18'h0, status.mode, status.ctrl}
                             : hit_res ? {16'h0, status.word} : 32'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            tg_s1 <= 1'b0;
            tg_s2 <= 1'b0;
            tg_s3 <= 1'b0;
            status <= '0;
            enable <= 1'b1;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            tg_s1 <= snap_tgl;
            tg_s2 <= tg_s1;
            tg_s3 <= tg_s2;
            if (tg_s2 != tg_s3) begin
                status <= snap;
            end
            if (wr_en) begin
                enable <= pwdata[0];
            end
            pready <= setup;
            prdata <= setup ? rd_val : 32'h0;
            pslverr <= setup && !(hit_en || hit_ctl || hit_res);
        end
    end

    // Checks
    chk_apb_ready: assert property (@(posedge clk) disable iff (rst)
        (psel && !penable) |=> pready)
        else $error("pready not one cycle after setup");
    chk_lead_zero: assert property (@(negedge sclk) disable iff (lrst)
        cs_n |=> !dout)
        else $error("idle output not the leading zero");
    chk_chan_field: assert property (@(negedge sclk) disable iff (lrst)
        (frame_on && cnt == 5'h00) |=> dout == mux_chan[2] ##1 dout == mux_chan[1])
        else $error("channel field mismatch");
    chk_code_msb: assert property (@(negedge sclk) disable iff (lrst)
        (frame_on && cnt == 5'h00)
        |=> word[11] == ($past(conv_code[11]) ^ ~ctrl[acs_pkg::CTRL_CODING]))
        else $error("coding of result MSB wrong");
    chk_ctrl_write: assert property (@(negedge sclk) disable iff (lrst)
        ctrl_load |=> ctrl == $past(next_shift[11:0]) && wrote)
        else $error("control word not loaded");
    chk_mask_load: assert property (@(negedge sclk) disable iff (lrst)
        (end_edge && mode == acs_pkg::ACS_ARMED && !wrote) |=> mask == $past(next_shift))
        else $error("mask not loaded");
    chk_mask_first: assert property (@(negedge sclk) disable iff (lrst)
        (end_edge && mode == acs_pkg::ACS_ARMED && !wrote && next_shift != 16'h0)
        |=> mode == acs_pkg::ACS_MASK && mask[~pos] && mux_chan == pos[2:0])
        else $error("first selected channel wrong");
    chk_consec_step: assert property (@(negedge sclk) disable iff (lrst)
        (end_edge && mode == acs_pkg::ACS_CONSEC && !wrote && mux_chan != addr)
        |=> mux_chan == $past(mux_chan) + 3'h1)
        else $error("consecutive step wrong");
    chk_consec_wrap: assert property (@(negedge sclk) disable iff (lrst)
        (end_edge && mode == acs_pkg::ACS_CONSEC && (!wrote || pat == 2'b10)
         && mux_chan == addr) |=> mux_chan == 3'h0)
        else $error("consecutive wrap wrong");
    chk_seq_exit: assert property (@(negedge sclk) disable iff (lrst)
        (end_edge && wrote && pat == 2'b00) |=> mode == acs_pkg::ACS_SINGLE
        && mux_chan == addr)
        else $error("sequence not ended");
    chk_seq_keep: assert property (@(negedge sclk) disable iff (lrst)
        (end_edge && wrote && pat == 2'b10 && mode == acs_pkg::ACS_MASK)
        |=> mode == acs_pkg::ACS_MASK)
        else $error("sequence interrupted");
    cov_mask_run: cover property (@(negedge sclk) disable iff (lrst)
        end_edge && mode == acs_pkg::ACS_MASK && step_slot[3:0] <= pos);
    cov_consec_wrap: cover property (@(negedge sclk) disable iff (lrst)
        end_edge && mode == acs_pkg::ACS_CONSEC && mux_chan == addr);
    cov_apb_read: cover property (@(posedge clk) disable iff (rst)
        psel && penable && pready && !pwrite && hit_res);
endmodule // acs_core
`default_nettype wire

// ---- core/acs_pkg.sv ----
// Purpose: Shared constants and types for the channel sequencer
// Assumes: 12-bit control word, 16-bit mask and result word
// Notes:   Control bits are numbered as shifted in, first bit = 11
package acs_pkg;
    localparam int CW = 12;
    localparam int WW = 16;
    localparam int CTRL_WRITE = 11;
    localparam int CTRL_SEQ = 10;
    localparam int CTRL_ADDR_HI = 8;
    localparam int CTRL_ADDR_LO = 6;
    localparam int CTRL_PM_HI = 5;
    localparam int CTRL_PM_LO = 4;
    localparam int CTRL_SHADOW = 3;
    localparam int CTRL_RANGE = 1;
    localparam int CTRL_CODING = 0;
    localparam logic [CW-1:0] CTRL_RST = 12'h000;
    localparam logic [4:0] BIT_CTRL_LAST = 5'h0B;
    localparam logic [4:0] BIT_LAST = 5'h0F;
    localparam logic [4:0] BIT_DONE = 5'h10;
    localparam logic [31:0] OFS_ENABLE = 32'h0000_0000;
    localparam logic [31:0] OFS_CONTROL = 32'h0000_0004;
    localparam logic [31:0] OFS_RESULT = 32'h0000_0008;

    typedef enum logic [1:0] {
        ACS_SINGLE = 2'b00,
        ACS_ARMED  = 2'b01,
        ACS_MASK   = 2'b10,
        ACS_CONSEC = 2'b11
    } acs_mode_e;

    typedef struct packed {
        acs_mode_e       mode;
        logic [CW-1:0]   ctrl;
        logic [WW-1:0]   word;
    } acs_snap_s;
endpackage

// ---- testbench/acs_host_model.sv ----
// Purpose: Host end of the serial link; frames of sixteen clocks
// Assumes: sclk idles high; each frame ends with three clocks while cs_n is high
// Notes:   Released dout line shows the inverse of the last bit
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout,
    input  wire logic dout_oe
);
    logic last = 1'b0;
    wire  line = dout_oe ? dout : ~last;

    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    always @(negedge sclk) begin
        if (dout_oe) begin
            last <= dout;
        end
    end

    task automatic idle(input int n);
        repeat (n) begin
            #24 sclk = 1'b0;
            #24 sclk = 1'b1;
        end
    endtask

    // Data set while sclk high, read after each falling edge but the last
    task automatic frame(input logic [15:0] wd, output logic [15:0] rd);
        rd = 16'h0000;
        cs_n = 1'b0;
        for (int k = 0; k < 16; k++) begin
            din = wd[15-k];
            #24 sclk = 1'b0;
            #24 if (k < 15) rd[14-k] = line;
            sclk = 1'b1;
        end
        // Chip select seen high before the next frame
        #24 cs_n = 1'b1;
        idle(3);
    endtask
endmodule // acs_host_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the channel sequencer
// Assumes: Converter code is a fixed pattern of the routed channel
// Notes:   Status is read over APB once a frame has ended
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sclk;
    logic        cs_n;
    logic        din;
    logic        dout;
    logic        dout_oe;
    logic [2:0]  mux_chan;
    logic        range_sel;
    logic [1:0]  power_mode;
    logic [15:0] rd;
    logic [31:0] r;
    logic        e;
    int          n_fail = 0;
    int          samples_checked = 0;
    wire  [11:0] conv_code = {1'b1, mux_chan, 8'h5A};

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    acs_core i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .dout_oe(dout_oe), .conv_code(conv_code),
        .mux_chan(mux_chan), .range_sel(range_sel), .power_mode(power_mode));
    acs_host_model i_host (.sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe(dout_oe));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [15:0] ctl(input logic sq, input logic sh,
                                        input logic [2:0] a, input logic cod);
        logic [11:0] c;
        c = 12'h000;
        c[acs_pkg::CTRL_WRITE] = 1'b1;
        c[acs_pkg::CTRL_SEQ] = sq;
        c[acs_pkg::CTRL_SHADOW] = sh;
        c[acs_pkg::CTRL_ADDR_HI:acs_pkg::CTRL_ADDR_LO] = a;
        c[acs_pkg::CTRL_PM_HI:acs_pkg::CTRL_PM_LO] = 2'b11;
        c[acs_pkg::CTRL_RANGE] = 1'b1;
        c[acs_pkg::CTRL_CODING] = cod;
        return {c, 4'h0};
    endfunction

    // Code MSB is 1, so twos complement shows it as 0
    function automatic logic [31:0] word(input logic [2:0] ch, input logic cod);
        return {17'h00000, ch, cod, ch, 8'h5A};
    endfunction

    // Write bit held low while a sequence runs
    task automatic expect_chan(input logic [2:0] ch, input logic cod);
        i_host.frame(16'h0000, rd);
        check({17'h00000, rd[14:0]}, word(ch, cod));
    endtask

    task automatic t_regs;
        apb(1'b0, acs_pkg::OFS_ENABLE, 32'h0);
        check(32'(r[0]), 32'h1);
        apb(1'b0, acs_pkg::OFS_CONTROL, 32'h0);
        check(r, 32'h0);
        check(32'(range_sel), 32'h0);
        apb(1'b1, 32'h0000_0040, 32'h5);
        check(32'(e), 32'h1);
        apb(1'b0, 32'h0000_0040, 32'h0);
        check(r, 32'h0);
    endtask

    task automatic t_single;
        i_host.frame(ctl(1'b0, 1'b0, 3'h5, 1'b1), rd);
        check(32'(mux_chan), 32'h5);
        check(32'(range_sel), 32'h1);
        check(32'(power_mode), 32'h3);
        expect_chan(3'h5, 1'b1);
        apb(1'b0, acs_pkg::OFS_RESULT, 32'h0);
        check({16'h0000, r[15:0]}, word(3'h5, 1'b1));
        i_host.frame(ctl(1'b0, 1'b0, 3'h3, 1'b0), rd);
        expect_chan(3'h3, 1'b0);
    endtask

    task automatic t_consec;
        i_host.frame(ctl(1'b1, 1'b1, 3'h2, 1'b1), rd);
        apb(1'b0, acs_pkg::OFS_CONTROL, 32'h0);
        check(r, 32'h0000_3000 | 32'(ctl(1'b1, 1'b1, 3'h2, 1'b1) >> 4));
        expect_chan(3'h0, 1'b1);
        expect_chan(3'h1, 1'b1);
        i_host.frame(ctl(1'b1, 1'b0, 3'h2, 1'b1), rd);
        check({17'h00000, rd[14:0]}, word(3'h2, 1'b1));
        expect_chan(3'h0, 1'b1);
        expect_chan(3'h1, 1'b1);
    endtask

    task automatic t_mask;
        i_host.frame(ctl(1'b0, 1'b1, 3'h0, 1'b1), rd);
        // Slots 2 and 5 first, then slot 9 on channel 1
        i_host.frame(16'h2440, rd);
        expect_chan(3'h2, 1'b1);
        expect_chan(3'h5, 1'b1);
        expect_chan(3'h1, 1'b1);
        expect_chan(3'h2, 1'b1);
        i_host.frame(ctl(1'b0, 1'b0, 3'h4, 1'b1), rd);
        check({17'h00000, rd[14:0]}, word(3'h5, 1'b1));
        check(32'(mux_chan), 32'h4);
    endtask

    task automatic t_disable;
        // Enable needs four link edges to reach the link side
        apb(1'b1, acs_pkg::OFS_ENABLE, 32'h0);
        i_host.idle(5);
        i_host.frame(ctl(1'b0, 1'b0, 3'h6, 1'b1), rd);
        check(32'(mux_chan), 32'h4);
        apb(1'b1, acs_pkg::OFS_ENABLE, 32'h1);
        i_host.idle(5);
        expect_chan(3'h4, 1'b1);
    endtask

    initial begin
        #400000;
        n_fail++;
        results();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        // Link reset needs sclk edges while reset is high
        #3;
        fork
            i_host.idle(6);
            repeat (5) @(posedge clk);
        join
        @(posedge clk);
        rst <= 1'b0;
        i_host.idle(6);
        t_regs();
        t_single();
        t_consec();
        t_mask();
        t_disable();
        results();
    end
endmodule // tb_top
`default_nettype wire
